// >>> hw/sdtg_gap_timer.v
`timescale 1ns/1ps
module sdtg_gap_timer (
  input wire mclk,
  input wire rstN,
  input wire tick,
  input wire load,
  input wire [7:0] loadValue,
  output wire done
);
  reg [7:0] count;

  // loaded with gap on the issuing tick, so gap+1 ticks pass before done
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      count <= 8'h00;
    end else if (load) begin
      count <= loadValue;
    end else if (tick && count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  assign done = (count == 8'h00);
endmodule

// >>> hw/sdtg_guard.v
`timescale 1ns/1ps
`include "sdtg_regs.vh"
module sdtg_guard (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  input wire ddrClk,
  input wire cmdReq,
  input wire [3:0] cmdType,
  input wire [2:0] cmdBank,
  output wire cmdGrant,
  input wire lastWriteData,
  input wire refreshTick,
  output reg [3:0] memCmd,
  output reg [2:0] memBank,
  output reg memCmdValid,
  output reg memCke,
  output wire [7:0] forcePrecharge,
  output reg initStart
);
  reg [1:0] rstSync;
  wire rstN;
  reg [31:0] timingPrimary;
  reg [31:0] timingSecondary;
  reg timingUnlock;
  reg [2:0] lastWrBank;
  reg [7:0] openBank;
  reg [7:0] forcePre;
  reg [31:0] next_rdata;
  reg allowBase;
  wire ddrRise;
  wire [7:0] rpDone;
  wire [7:0] rcdDone;
  wire [7:0] rasDone;
  wire [7:0] rcDone;
  wire [7:0] rtpDone;
  wire [7:0] wrDone;
  wire rfcDone;
  wire rrdDone;
  wire wtrDone;
  wire xpDone;
  wire xsnrDone;
  wire xsrdDone;
  wire ckeDone;
  wire nonReadOk;
  wire [31:0] primaryWritten;
  wire [31:0] secondaryWritten;
  wire [3:0] grantCmd = cmdGrant ? cmdType : `SDTG_CMD_NOP;

  function isNonRead;
    input [3:0] kind;
    begin
      isNonRead = (kind != `SDTG_CMD_READ) && (kind != `SDTG_CMD_NOP);
    end
  endfunction

  function isCmd;
    input [3:0] kind;
    input [3:0] want;
    begin
      isCmd = (kind == want);
    end
  endfunction

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  sdtg_link_sync linkSync (
    .mclk(mclk),
    .rstN(rstN),
    .ddrClk(ddrClk),
    .ddrRise(ddrRise)
  );

  assign primaryWritten = regWdata & `SDTG_MASK_PRIMARY;
  assign secondaryWritten = regWdata & `SDTG_MASK_SECONDARY;

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      timingPrimary <= `SDTG_RST_PRIMARY;
      timingSecondary <= `SDTG_RST_SECONDARY;
      timingUnlock <= 1'b0;
      initStart <= 1'b0;
    end else begin
      initStart <= 1'b0;
      if (regWr && regAddr == `SDTG_OFS_CONTROL) begin
        timingUnlock <= regWdata[`SDTG_B_UNLOCK];
      end
      if (regWr && regAddr == `SDTG_OFS_PRIMARY && timingUnlock) begin
        timingPrimary <= primaryWritten;
        // only a real change of write recovery restarts the memory
        initStart <= primaryWritten[`SDTG_F_WR] != timingPrimary[`SDTG_F_WR];
      end
      if (regWr && regAddr == `SDTG_OFS_SECONDARY && timingUnlock) begin
        timingSecondary <= secondaryWritten;
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (regAddr)
      `SDTG_OFS_PRIMARY: next_rdata = timingPrimary;
      `SDTG_OFS_SECONDARY: next_rdata = timingSecondary;
      `SDTG_OFS_CONTROL: next_rdata = {31'h00000000, timingUnlock};
      `SDTG_OFS_STATUS: next_rdata = {15'h0000, memCke, forcePre, openBank};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // global spacing timers
  sdtg_gap_timer rfcTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(isCmd(grantCmd, `SDTG_CMD_REFRESH) || isCmd(grantCmd, `SDTG_CMD_LOAD_MODE)),
    .loadValue({1'b0, timingPrimary[`SDTG_F_RFC]}),
    .done(rfcDone)
  );

  sdtg_gap_timer rrdTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(isCmd(grantCmd, `SDTG_CMD_ACTIVATE)),
    .loadValue({5'h00, timingPrimary[`SDTG_F_RRD]}),
    .done(rrdDone)
  );

  sdtg_gap_timer wtrTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(lastWriteData),
    .loadValue({6'h00, timingPrimary[`SDTG_F_WTR]}),
    .done(wtrDone)
  );

  sdtg_gap_timer xpTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(isCmd(grantCmd, `SDTG_CMD_PD_EXIT)),
    .loadValue({6'h00, timingSecondary[`SDTG_F_XP]}),
    .done(xpDone)
  );

  sdtg_gap_timer xsnrTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(isCmd(grantCmd, `SDTG_CMD_SR_EXIT)),
    .loadValue({1'b0, timingSecondary[`SDTG_F_XSNR]}),
    .done(xsnrDone)
  );

  sdtg_gap_timer xsrdTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(isCmd(grantCmd, `SDTG_CMD_SR_EXIT)),
    .loadValue(timingSecondary[`SDTG_F_XSRD]),
    .done(xsrdDone)
  );

  sdtg_gap_timer ckeTimer (
    .mclk(mclk),
    .rstN(rstN),
    .tick(ddrRise),
    .load(isCmd(grantCmd, `SDTG_CMD_CKE_LOW) || isCmd(grantCmd, `SDTG_CMD_PD_EXIT) ||
          isCmd(grantCmd, `SDTG_CMD_SR_EXIT)),
    .loadValue({3'h0, timingSecondary[`SDTG_F_CKE]}),
    .done(ckeDone)
  );

  // per-bank timers and row-open supervision
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : bankGuard
      wire hit;
      reg [3:0] openTicks;
      localparam [2:0] BANK_ID = b;
      assign hit = (cmdBank == BANK_ID);

      sdtg_gap_timer rpTimer (
        .mclk(mclk),
        .rstN(rstN),
        .tick(ddrRise),
        .load(isCmd(grantCmd, `SDTG_CMD_PRECHARGE) && hit),
        .loadValue({5'h00, timingPrimary[`SDTG_F_RP]}),
        .done(rpDone[b])
      );

      sdtg_gap_timer rcdTimer (
        .mclk(mclk),
        .rstN(rstN),
        .tick(ddrRise),
        .load(isCmd(grantCmd, `SDTG_CMD_ACTIVATE) && hit),
        .loadValue({5'h00, timingPrimary[`SDTG_F_RCD]}),
        .done(rcdDone[b])
      );

      sdtg_gap_timer rasTimer (
        .mclk(mclk),
        .rstN(rstN),
        .tick(ddrRise),
        .load(isCmd(grantCmd, `SDTG_CMD_ACTIVATE) && hit),
        .loadValue({3'h0, timingPrimary[`SDTG_F_RAS]}),
        .done(rasDone[b])
      );

      sdtg_gap_timer rcTimer (
        .mclk(mclk),
        .rstN(rstN),
        .tick(ddrRise),
        .load(isCmd(grantCmd, `SDTG_CMD_ACTIVATE) && hit),
        .loadValue({3'h0, timingPrimary[`SDTG_F_RC]}),
        .done(rcDone[b])
      );

      sdtg_gap_timer rtpTimer (
        .mclk(mclk),
        .rstN(rstN),
        .tick(ddrRise),
        .load(isCmd(grantCmd, `SDTG_CMD_READ) && hit),
        .loadValue({5'h00, timingSecondary[`SDTG_F_RTP]}),
        .done(rtpDone[b])
      );

      sdtg_gap_timer wrTimer (
        .mclk(mclk),
        .rstN(rstN),
        .tick(ddrRise),
        .load(lastWriteData && lastWrBank == BANK_ID),
        .loadValue({5'h00, timingPrimary[`SDTG_F_WR]}),
        .done(wrDone[b])
      );

      // counts refresh intervals while the row stays open
      always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
          openBank[b] <= 1'b0;
          forcePre[b] <= 1'b0;
          openTicks <= 4'h0;
        end else if (isCmd(grantCmd, `SDTG_CMD_PRECHARGE) && hit) begin
          openBank[b] <= 1'b0;
          forcePre[b] <= 1'b0;
          openTicks <= 4'h0;
        end else if (isCmd(grantCmd, `SDTG_CMD_ACTIVATE) && hit) begin
          openBank[b] <= 1'b1;
          openTicks <= 4'h0;
        end else if (openBank[b] && refreshTick) begin
          if (openTicks == timingSecondary[`SDTG_F_RASMAX]) begin
            forcePre[b] <= 1'b1;
          end else begin
            openTicks <= openTicks + 4'h1;
          end
        end
      end
    end
  endgenerate

  assign forcePrecharge = forcePre;

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      lastWrBank <= 3'h0;
    end else if (isCmd(grantCmd, `SDTG_CMD_WRITE)) begin
      lastWrBank <= cmdBank;
    end
  end

  assign nonReadOk = xpDone && xsnrDone;

  // a command passes only once every constraint on it has run out
  always @* begin
    allowBase = 1'b0;
    case (cmdType)
      `SDTG_CMD_REFRESH, `SDTG_CMD_LOAD_MODE: allowBase = rfcDone && (&rpDone);
      `SDTG_CMD_PRECHARGE: begin
        allowBase = rasDone[cmdBank] && wrDone[cmdBank] && rtpDone[cmdBank];
      end
      `SDTG_CMD_ACTIVATE: begin
        allowBase = rfcDone && rpDone[cmdBank] && rcDone[cmdBank] && rrdDone;
      end
      `SDTG_CMD_READ: begin
        allowBase = rcdDone[cmdBank] && wtrDone && xsrdDone && !forcePre[cmdBank];
      end
      `SDTG_CMD_WRITE: allowBase = rcdDone[cmdBank] && !forcePre[cmdBank];
      `SDTG_CMD_CKE_LOW: allowBase = ckeDone && memCke;
      `SDTG_CMD_PD_EXIT, `SDTG_CMD_SR_EXIT: allowBase = ckeDone && !memCke;
      default: allowBase = 1'b0;
    endcase
  end

  // commands only leave on a memory clock rising edge
  assign cmdGrant = cmdReq && ddrRise && allowBase &&
                    (!isNonRead(cmdType) || nonReadOk);

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      memCmd <= `SDTG_CMD_NOP;
      memBank <= 3'h0;
      memCmdValid <= 1'b0;
      memCke <= 1'b0;
    end else begin
      memCmdValid <= cmdGrant;
      if (cmdGrant) begin
        memCmd <= cmdType;
        memBank <= cmdBank;
      end
      if (isCmd(grantCmd, `SDTG_CMD_CKE_LOW)) begin
        memCke <= 1'b0;
      end else if (isCmd(grantCmd, `SDTG_CMD_PD_EXIT) || isCmd(grantCmd, `SDTG_CMD_SR_EXIT)) begin
        memCke <= 1'b1;
      end
    end
  end
endmodule

// >>> hw/sdtg_link_sync.v
`timescale 1ns/1ps
module sdtg_link_sync (
  input wire mclk,
  input wire rstN,
  input wire ddrClk,
  output wire ddrRise
);
  reg [2:0] stage;

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], ddrClk};
    end
  end

  // edge found between second and third stage, first stage only feeds the second
  assign ddrRise = stage[1] & ~stage[2];
endmodule

// >>> hw/sdtg_regs.vh
// Operation
// - refresh/load-mode to refresh/activate: rfc gap+1
// - precharge to refresh/activate: rp gap+1
// - activate to read/write: rcd gap+1
// - last write data to precharge: wr gap+1
// - changed write recovery write starts init
// - activate to precharge: ras gap+1
// - activate to activate: rc gap+1
// - activate to other-bank activate: rrd gap+1
// - last write to read: wtr gap+1
// - secondary register writable only when unlocked
// - primary register writable only when unlocked
// - row open at most limit+1 refresh intervals
// - power-down exit to non-read: xp gap+1
// - self-refresh exit to non-read: xsnr gap+1
// - self-refresh exit to read: xsrd gap+1
// - read to precharge: rtp gap+1
// - clock-enable held stable cke gap+1
`ifndef SDTG_REGS_VH
`define SDTG_REGS_VH

`define SDTG_OFS_PRIMARY 8'h00
`define SDTG_OFS_SECONDARY 8'h04
`define SDTG_OFS_CONTROL 8'h08
`define SDTG_OFS_STATUS 8'h0C

`define SDTG_RST_PRIMARY 32'h356B4B9B
`define SDTG_RST_SECONDARY 32'h001DF145
`define SDTG_MASK_PRIMARY 32'hFFFFFFFB
`define SDTG_MASK_SECONDARY 32'h7E7FFFFF

`define SDTG_F_RFC 31:25
`define SDTG_F_RP 24:22
`define SDTG_F_RCD 21:19
`define SDTG_F_WR 18:16
`define SDTG_F_RAS 15:11
`define SDTG_F_RC 10:6
`define SDTG_F_RRD 5:3
`define SDTG_F_WTR 1:0
`define SDTG_F_RASMAX 30:27
`define SDTG_F_XP 26:25
`define SDTG_F_XSNR 22:16
`define SDTG_F_XSRD 15:8
`define SDTG_F_RTP 7:5
`define SDTG_F_CKE 4:0
`define SDTG_B_UNLOCK 0

`define SDTG_CMD_NOP 4'h0
`define SDTG_CMD_REFRESH 4'h1
`define SDTG_CMD_LOAD_MODE 4'h2
`define SDTG_CMD_PRECHARGE 4'h3
`define SDTG_CMD_ACTIVATE 4'h4
`define SDTG_CMD_READ 4'h5
`define SDTG_CMD_WRITE 4'h6
`define SDTG_CMD_CKE_LOW 4'h7
`define SDTG_CMD_PD_EXIT 4'h8
`define SDTG_CMD_SR_EXIT 4'h9

`endif

// >>> test/sdtg_guard_assertions.sv
`timescale 1ns/1ps
`include "sdtg_regs.vh"
module sdtg_guard_checker (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire cmdReq,
  input wire [3:0] cmdType,
  input wire [2:0] cmdBank,
  input wire cmdGrant,
  input wire refreshTick,
  input wire [3:0] memCmd,
  input wire [2:0] memBank,
  input wire memCmdValid,
  input wire memCke,
  input wire [7:0] forcePrecharge,
  input wire initStart
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic unlock;
  logic initDue;
  logic [2:0] wrShadow;
  wire primWr = regWr && regAddr == `SDTG_OFS_PRIMARY;
  // shadow of what software has set, to predict the init request
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      unlock <= 1'b0;
      initDue <= 1'b0;
      wrShadow <= 3'h3;
    end else begin
      initDue <= primWr && unlock && regWdata[18:16] != wrShadow;
      if (regWr && regAddr == `SDTG_OFS_CONTROL)
        unlock <= regWdata[0];
      if (primWr && unlock)
        wrShadow <= regWdata[18:16];
    end
  end
  AST_LOCKED_NO_INIT: assert property (primWr && !unlock |=> !initStart)
    else $error("locked write started init");
  AST_INIT_ON_CHANGE: assert property (initStart == initDue)
    else $error("init request does not match field change");
  AST_GRANT_REQ: assert property (cmdGrant |-> cmdReq)
    else $error("grant without request");
  AST_ISSUE: assert property (cmdGrant |=> memCmdValid && memCmd == $past(cmdType)
    && memBank == $past(cmdBank))
    else $error("granted command not issued");
  AST_GRANT_SPACING: assert property (cmdGrant |=> !cmdGrant [*8])
    else $error("grants too close");
  AST_CKE_STABLE: assert property ($changed(memCke) |=> $stable(memCke) [*8])
    else $error("clock-enable toggled too soon");
  AST_CKE_RISE: assert property ($rose(memCke) |-> memCmdValid &&
    (memCmd == `SDTG_CMD_PD_EXIT || memCmd == `SDTG_CMD_SR_EXIT))
    else $error("clock-enable rose without exit");
  AST_ACCESS_FORCED: assert property (cmdGrant && (cmdType == `SDTG_CMD_READ ||
    cmdType == `SDTG_CMD_WRITE) |-> !forcePrecharge[cmdBank])
    else $error("access granted to expired row");
  AST_FORCE_TICK: assert property ((forcePrecharge & ~$past(forcePrecharge)) != 8'h00
    |-> $past(refreshTick))
    else $error("row limit flagged without tick");
  COV_READ: cover property (cmdGrant && cmdType == `SDTG_CMD_READ);
  COV_CKE: cover property ($rose(memCke));
  COV_INIT: cover property (initStart);
  COV_FORCE: cover property (forcePrecharge != 8'h00);
endmodule
bind sdtg_guard sdtg_guard_checker sdtg_guard_checker_inst (.mclk, .reset_n, .regAddr,
  .regWdata, .regWr, .cmdReq, .cmdType, .cmdBank, .cmdGrant, .refreshTick, .memCmd,
  .memBank, .memCmdValid, .memCke, .forcePrecharge, .initStart);

// >>> test/sdtg_mem_model.sv
`timescale 1ns/1ps
`include "sdtg_regs.vh"
module sdtg_mem_model (
  input wire mclk,
  input wire [3:0] memCmd,
  input wire memCmdValid,
  input wire memCke,
  output logic ddrClk,
  output int protoErrors
);
  logic ckeSeen = 1'b0;
  int errCount = 0;
  assign protoErrors = errCount;
  // odd start keeps the memory clock out of phase with mclk
  initial begin
    ddrClk = 1'b0;
    #37;
    forever #80 ddrClk = ~ddrClk;
  end
  // exits only from low clock-enable, everything else only from high
  always @(posedge mclk) begin
    if (memCmdValid) begin
      if ((memCmd == `SDTG_CMD_PD_EXIT || memCmd == `SDTG_CMD_SR_EXIT) == ckeSeen)
        errCount <= errCount + 1;
      ckeSeen <= memCke;
    end
  end
endmodule

// >>> test/tb_sdram_command_timing_guard.sv
`timescale 1ns/1ps
`include "sdtg_regs.vh"
module tb_sdram_command_timing_guard;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic cmdReq = 1'b0;
  logic [3:0] cmdType = 4'h0;
  logic [2:0] cmdBank = 3'h0;
  logic lastWriteData = 1'b0;
  logic refreshTick = 1'b0;
  logic ddrSeen = 1'b0;
  logic [31:0] rd;
  wire [31:0] regRdata;
  wire ddrClk, cmdGrant, memCmdValid, memCke, initStart;
  wire [3:0] memCmd;
  wire [2:0] memBank;
  wire [7:0] forcePrecharge;
  int protoErrors;
  int failures = 0;
  int totalChecks = 0;
  int cycles = 0;
  int rises = 0;
  int lastRises = 0;

  always #5 mclk = ~mclk;

  sdtg_guard sdtg_guard_inst (.mclk, .reset_n, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .ddrClk, .cmdReq, .cmdType, .cmdBank, .cmdGrant, .lastWriteData,
    .refreshTick, .memCmd, .memBank, .memCmdValid, .memCke, .forcePrecharge, .initStart);
  sdtg_mem_model sdtg_mem_model_inst (.mclk, .memCmd, .memCmdValid, .memCke, .ddrClk,
    .protoErrors);

  task automatic wrap_up;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // gaps are measured in memory clock rises seen from mclk
  always @(posedge mclk) begin
    ddrSeen <= ddrClk;
    if (ddrClk && !ddrSeen)
      rises <= rises + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    totalChecks++;
    if (seen !== expected) begin
      failures++;
      $display("FAIL at %0t seen %08h expected %08h", $time, seen, expected);
    end
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge mclk);
    regAddr <= addr;
    regWdata <= data;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic reg_read(input logic [7:0] addr);
    @(posedge mclk);
    regAddr <= addr;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    rd = regRdata;
  endtask

  task automatic issue(input logic [3:0] kind, input logic [2:0] bank, input int gap);
    int waited;
    waited = 0;
    @(posedge mclk);
    cmdReq <= 1'b1;
    cmdType <= kind;
    cmdBank <= bank;
    @(negedge mclk);
    while (cmdGrant !== 1'b1 && waited < 400) begin
      @(negedge mclk);
      waited++;
    end
    check(waited < 400, 1'b1);
    if (gap > 0)
      check(rises - lastRises, gap);
    lastRises = rises;
    @(posedge mclk);
    cmdReq <= 1'b0;
    @(negedge mclk);
    check({memCmdValid, memCmd, memBank}, {1'b1, kind, bank});
  endtask

  task automatic pulse_tick;
    @(posedge mclk);
    refreshTick <= 1'b1;
    @(posedge mclk);
    refreshTick <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic test_registers;
    reg_read(`SDTG_OFS_PRIMARY);
    check(rd, 32'h356B4B9B);
    reg_read(`SDTG_OFS_SECONDARY);
    check(rd, 32'h001DF145);
    reg_write(`SDTG_OFS_PRIMARY, 32'hFFFFFFFB);
    check(initStart, 1'b0);
    reg_read(`SDTG_OFS_PRIMARY);
    check(rd, 32'h356B4B9B);
    reg_write(`SDTG_OFS_CONTROL, 32'h1);
    reg_write(`SDTG_OFS_SECONDARY, 32'h0A020743);
    reg_read(`SDTG_OFS_SECONDARY);
    check(rd, 32'h0A020743);
    reg_write(`SDTG_OFS_PRIMARY, 32'h045D2A91);
    check(initStart, 1'b1);
    reg_read(`SDTG_OFS_PRIMARY);
    check(rd, 32'h045D2A91);
    reg_write(`SDTG_OFS_PRIMARY, 32'h045D2A91);
    check(initStart, 1'b0);
    reg_read(8'h10);
    check(rd, 32'h0);
    reg_write(`SDTG_OFS_CONTROL, 32'h0);
    reg_read(`SDTG_OFS_CONTROL);
    check(rd, 32'h0);
    reg_write(`SDTG_OFS_SECONDARY, 32'h0);
    reg_read(`SDTG_OFS_SECONDARY);
    check(rd, 32'h0A020743);
    $display("test_registers done");
  endtask

  task automatic test_commands;
    issue(`SDTG_CMD_SR_EXIT, 3'h0, 0);
    check(memCke, 1'b1);
    issue(`SDTG_CMD_ACTIVATE, 3'h0, 3);
    issue(`SDTG_CMD_ACTIVATE, 3'h1, 3);
    issue(`SDTG_CMD_READ, 3'h0, 2);
    issue(`SDTG_CMD_PRECHARGE, 3'h0, 3);
    issue(`SDTG_CMD_ACTIVATE, 3'h0, 3);
    issue(`SDTG_CMD_WRITE, 3'h0, 4);
    @(posedge mclk);
    lastWriteData <= 1'b1;
    @(posedge mclk);
    lastWriteData <= 1'b0;
    issue(`SDTG_CMD_READ, 3'h0, 2);
    issue(`SDTG_CMD_PRECHARGE, 3'h0, 4);
    issue(`SDTG_CMD_REFRESH, 3'h0, 2);
    issue(`SDTG_CMD_ACTIVATE, 3'h0, 3);
    issue(`SDTG_CMD_CKE_LOW, 3'h0, 1);
    check(memCke, 1'b0);
    issue(`SDTG_CMD_PD_EXIT, 3'h0, 4);
    issue(`SDTG_CMD_ACTIVATE, 3'h2, 2);
    $display("test_commands done");
  endtask

  task automatic test_row_limit;
    pulse_tick();
    check(forcePrecharge, 8'h00);
    pulse_tick();
    check(forcePrecharge, 8'h07);
    issue(`SDTG_CMD_PRECHARGE, 3'h2, 0);
    check(forcePrecharge, 8'h03);
    issue(`SDTG_CMD_LOAD_MODE, 3'h0, 2);
    issue(`SDTG_CMD_REFRESH, 3'h0, 3);
    reg_read(`SDTG_OFS_STATUS);
    check(rd, 32'h00010303);
    check(protoErrors, 0);
    $display("test_row_limit done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
    test_registers();
    test_commands();
    test_row_limit();
    wrap_up();
  end
endmodule
